/* File: dv/canceller_serial_control_word_properties.sv */
// Assertions on the ports of the canceller serial control word block.
// Assumes the select stays high through reset and for three clk cycles between frames.
`timescale 1ns/1ps
`default_nettype none
module scw_properties (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       serial_select_low,
	input wire logic [9:0] i_dac_value,
	input wire logic [9:0] q_dac_value,
	input wire logic [1:0] band_select,
	input wire logic       band_undefined,
	input wire logic       gain_switch,
	input wire logic       extended_bit,
	input wire logic       boost_mode,
	input wire logic       boost_armed,
	input wire logic       word_strobe
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	strobe_pulse_a: assert property (word_strobe |=> !word_strobe)
		else $error("word strobe longer than one cycle");
	commit_delay_a: assert property ($rose(serial_select_low) |-> ##[1:4] word_strobe)
		else $error("no word commit after select rose");
	word_hold_a: assert property (!word_strobe |-> $stable({i_dac_value, q_dac_value,
		band_select, gain_switch, extended_bit, boost_mode})) else $error("word changed without strobe");
	band_flag_a: assert property (band_undefined == (band_select == 2'h2))
		else $error("undefined band flag wrong");
	strobe_idle_a: assert property (word_strobe |-> $past(serial_select_low, 2))
		else $error("commit while select low");
	boost_on_a: assert property ($rose(boost_mode) |-> word_strobe && !extended_bit)
		else $error("boost set without second word");
	boost_off_a: assert property ($fell(boost_mode) |-> $past(boost_armed) && !extended_bit)
		else $error("boost cleared without armed pair");
	arm_first_a: assert property (word_strobe && extended_bit && ^band_select |-> boost_armed)
		else $error("first boost word not armed");
	reset_clear_a: assert property (disable iff (1'b0) srst |=> !{i_dac_value,
		q_dac_value, band_select, gain_switch, extended_bit, boost_mode, boost_armed})
		else $error("word not cleared by reset");
endmodule
bind canceller_serial_control_word scw_properties scw_properties_i (.clk, .srst,
	.serial_select_low, .i_dac_value, .q_dac_value, .band_select, .band_undefined,
	.gain_switch, .extended_bit, .boost_mode, .boost_armed, .word_strobe);
`default_nettype wire

/* File: dv/canceller_serial_control_word_tb.sv */
// Self-checking bench of the canceller serial control word block.
// Assumes the host model in serial_host drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module canceller_serial_control_word_tb;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       chip_active_low = 1'b1;
	wire        sclk, serial_select_low, serial_data;
	logic [9:0] i_dac_value, q_dac_value;
	logic [1:0] band_select;
	logic       band_undefined, gain_switch, extended_bit, boost_mode;
	logic       boost_armed, word_strobe, chip_active;
	int         n_mismatch = 0;
	int         compares = 0;
	always #12.5 clk = ~clk;
	serial_host serial_host_i (.sclk, .serial_select_low, .serial_data);
	canceller_serial_control_word canceller_serial_control_word_i (.clk, .srst, .sclk,
		.serial_select_low, .serial_data, .chip_active_low, .i_dac_value, .q_dac_value,
		.band_select, .band_undefined, .gain_switch, .extended_bit, .boost_mode,
		.boost_armed, .word_strobe, .chip_active);
	task end_sim;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic put(input logic [23:0] w, input int gap);
		int n;
		n = 0;
		serial_host_i.send(w, gap);
		while (word_strobe !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		if (word_strobe !== 1'b1) begin
			n_mismatch++;
			end_sim;
		end
		`CHK({extended_bit, gain_switch, band_select, q_dac_value, i_dac_value}, w)
		`CHK(band_undefined, w[21:20] == 2'h2)
		repeat (4) @(negedge clk);
	endtask
	task t_reset;
		@(negedge clk);
		srst = 1'b1;
		chip_active_low = 1'b0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK({extended_bit, gain_switch, band_select, q_dac_value, i_dac_value}, 24'h00_0000)
		`CHK({boost_mode, boost_armed}, 2'h0)
		`CHK(chip_active, 1'b0)
		@(negedge clk);
		`CHK(chip_active, 1'b1)
		chip_active_low = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(chip_active, 1'b0)
		chip_active_low = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(chip_active, 1'b1)
	endtask
	task t_fields;
		for (int b = 0; b < 4; b++) begin
			put({1'b0, b[0], b[1:0], 10'h3C5, 10'h21A ^ b[9:0]}, b * 40);
			`CHK(boost_mode, 1'b0)
		end
		put(24'h7F_FFFF, 0);
	endtask
	task t_boost;
		put(24'h91_2345, 0);
		`CHK({boost_mode, boost_armed}, 2'h1)
		put(24'h7F_EDCB, 80);
		`CHK({boost_mode, boost_armed}, 2'h2)
		put(24'hE2_0001, 0);
		`CHK({boost_mode, boost_armed}, 2'h3)
		put(24'h00_0002, 0);
		`CHK({boost_mode, boost_armed}, 2'h0)
		put(24'h91_0000, 0);
		`CHK({boost_mode, boost_armed}, 2'h1)
		put(24'hA2_0000, 0);
		`CHK({boost_mode, boost_armed}, 2'h1)
		put(24'hB3_0000, 0);
		`CHK({boost_mode, boost_armed}, 2'h0)
		put(24'h91_0000, 0);
		put(24'h00_0003, 0);
		`CHK({boost_mode, boost_armed}, 2'h2)
	endtask
	task t_stray;
		logic s;
		s = 1'b0;
		fork
			serial_host_i.stray(8);
			repeat (44) @(negedge clk) s = s | word_strobe;
		join
		`CHK(s, 1'b0)
		`CHK({extended_bit, q_dac_value, i_dac_value}, 21'h00_0003)
	endtask
	initial begin
		t_reset;
		t_fields;
		t_boost;
		t_stray;
		t_reset;
		end_sim;
	end
endmodule
`default_nettype wire

/* File: dv/serial_host.sv */
// Host model that drives the three-wire serial port of the canceller.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	output logic sclk,
	output logic serial_select_low,
	output logic serial_data
);
	initial begin
		sclk = 1'b0;
		serial_select_low = 1'b1;
		serial_data = 1'b0;
	end
	// Word bit 0 goes first; a larger gap models a slow host.
	task automatic send(input logic [23:0] w, input int gap);
		serial_select_low = 1'b0;
		#(40 + gap);
		for (int k = 0; k < 24; k++) begin
			serial_data = w[k];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		serial_select_low = 1'b1;
		// A released data line must not keep showing the last bit.
		serial_data = ~serial_data;
	endtask
	task automatic stray(input int n);
		for (int k = 0; k < n; k++) begin
			serial_data = ~serial_data;
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: rtl/canceller_defs.svh */
// Constants of the canceller serial control word: field positions, codes and reset values.
// Assumes it is included by bare name from every file of the block except the package.
`ifndef CANCELLER_DEFS_SVH
`define CANCELLER_DEFS_SVH

`define WORD_W          24
`define I_DAC_LSB       0
`define I_DAC_MSB       9
`define Q_DAC_LSB       10
`define Q_DAC_MSB       19
`define BAND_LSB        20
`define BAND_MSB        21
`define GAIN_BIT        22
`define EXT_BIT         23
`define WORD_RESET      24'h00_0000
`define BAND_UHF        2'h0
`define BAND_L          2'h1
`define BAND_UNDEF      2'h2
`define BAND_ISM        2'h3
`define BOOST_ON_CODE   2'h1
`define BOOST_OFF_CODE  2'h2
`define SEL_IDLE        1'b1
`define ENABLE_IDLE     1'b1

`endif

/* File: rtl/canceller_pkg.sv */
// Types shared by the canceller serial control word block.
// Assumes nothing beyond a SystemVerilog compiler.
package canceller_pkg;

	typedef enum logic [1:0] {
		BAND_SEL_UHF   = 2'h0,
		BAND_SEL_L     = 2'h1,
		BAND_SEL_UNDEF = 2'h2,
		BAND_SEL_ISM   = 2'h3
	} band_t;

	typedef enum logic [2:0] {
		BOOST_IDLE    = 3'h1,
		BOOST_ARM_ON  = 3'h2,
		BOOST_ARM_OFF = 3'h4
	} boost_state_t;

endpackage

/* File: rtl/canceller_serial_control_word.sv */
// Write-only serial control port of the interference canceller.
// Assumes the host drives sclk, serial_data and serial_select_low, and that clk runs freely.
// Assumes the host holds sclk still for at least three clk cycles after the select rises.
`timescale 1ns/1ps
`default_nettype none
`include "canceller_defs.svh"

module canceller_serial_control_word (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        sclk,
	input  wire logic        serial_select_low,
	input  wire logic        serial_data,
	input  wire logic        chip_active_low,
	output logic [9:0]       i_dac_value,
	output logic [9:0]       q_dac_value,
	output logic [1:0]       band_select,
	output logic             band_undefined,
	output logic             gain_switch,
	output logic             extended_bit,
	output logic             boost_mode,
	output logic             boost_armed,
	output logic             word_strobe,
	output logic             chip_active
);

	serial_word_if bus ();

	// The shifter runs on the host's clock and has no reset; only whole frames mean anything.
	serial_frame_shifter u_shifter (
		.sclk              (sclk),
		.serial_select_low (serial_select_low),
		.serial_data       (serial_data),
		.bus               (bus.link)
	);

	// Select and enable pins cross into clk through two flip-flops each.
	// A select pulse shorter than three clk cycles may be missed; the host must allow for that.
	logic sel_meta_reg;
	logic sel_sync_reg;
	logic sel_prev_reg;
	logic act_meta_reg;
	logic act_sync_reg;

	// The select resets to its idle level so that leaving reset shows no false rising edge.
	always_ff @(posedge clk) begin
		if (srst) begin
			sel_meta_reg <= `SEL_IDLE;
			sel_sync_reg <= `SEL_IDLE;
			sel_prev_reg <= `SEL_IDLE;
		end else begin
			sel_meta_reg <= serial_select_low;
			sel_sync_reg <= sel_meta_reg;
			sel_prev_reg <= sel_sync_reg;
		end
	end

	// The enable pin carries no timing of its own here; it is only resynchronised and shown.
	always_ff @(posedge clk) begin
		if (srst) begin
			act_meta_reg <= `ENABLE_IDLE;
			act_sync_reg <= `ENABLE_IDLE;
		end else begin
			act_meta_reg <= chip_active_low;
			act_sync_reg <= act_meta_reg;
		end
	end

	// The frame is sampled only after the select has risen and passed the synchroniser.
	// By then the serial clock is still, so the shifter contents are stable words.
	wire frame_done;
	assign frame_done = sel_sync_reg & ~sel_prev_reg;

	// Frame position n lands on word bit 23 - n.
	wire [`WORD_W-1:0] word_bits;
	genvar n;
	generate
		for (n = 0; n < `WORD_W; n = n + 1) begin : g_map
			assign word_bits[`WORD_W-1-n] = bus.frame_bits[n];
		end
	endgenerate

	// Only the extended bit and band code steer the boost sequence; the gain bit plays no part.
	wire       word_ext;
	wire [1:0] word_band;
	assign word_ext  = word_bits[`EXT_BIT];
	assign word_band = word_bits[`BAND_MSB:`BAND_LSB];

	// A word with the extended bit set arms a boost change by its band code.
	function automatic canceller_pkg::boost_state_t arm_decode(
		input logic       ext,
		input logic [1:0] band
	);
		canceller_pkg::boost_state_t result;
		result = canceller_pkg::BOOST_IDLE;
		if (ext && band == `BOOST_ON_CODE) begin
			result = canceller_pkg::BOOST_ARM_ON;
		end else if (ext && band == `BOOST_OFF_CODE) begin
			result = canceller_pkg::BOOST_ARM_OFF;
		end
		return result;
	endfunction

	canceller_pkg::boost_state_t state_reg;
	canceller_pkg::boost_state_t state_next;
	logic                        boost_reg;
	logic                        boost_next;

	// A second word with the extended bit set does not complete a change.
	// It is judged afresh as a possible first word, so a host can restart a sequence.
	always_comb begin
		state_next = state_reg;
		boost_next = boost_reg;
		case (state_reg)
			canceller_pkg::BOOST_IDLE: begin
				if (frame_done) begin
					state_next = arm_decode(word_ext, word_band);
				end
			end
			canceller_pkg::BOOST_ARM_ON: begin
				if (frame_done) begin
					if (!word_ext) begin
						boost_next = 1'b1;
						state_next = canceller_pkg::BOOST_IDLE;
					end else begin
						state_next = arm_decode(word_ext, word_band);
					end
				end
			end
			canceller_pkg::BOOST_ARM_OFF: begin
				if (frame_done) begin
					if (!word_ext) begin
						boost_next = 1'b0;
						state_next = canceller_pkg::BOOST_IDLE;
					end else begin
						state_next = arm_decode(word_ext, word_band);
					end
				end
			end
			default: begin
				state_next = canceller_pkg::BOOST_IDLE;
			end
		endcase
	end

	logic [`WORD_W-1:0] canceller_control_word_reg;
	logic               band_undef_reg;
	logic               strobe_reg;
	logic               active_reg;
	logic               armed_reg;

	// Between commits the word recirculates and the outputs hold their last value.
	wire [`WORD_W-1:0] control_word_next;
	assign control_word_next = frame_done ? word_bits : canceller_control_word_reg;

	// The flag is taken from the next word so that it changes on the same edge as the band code.
	wire band_undef_next;
	assign band_undef_next = (control_word_next[`BAND_MSB:`BAND_LSB] == `BAND_UNDEF);

	// Armed comes from the next state so the pin is a flip-flop with the state's own timing.
	wire armed_next;
	assign armed_next = (state_next != canceller_pkg::BOOST_IDLE);

	always_ff @(posedge clk) begin
		if (srst) begin
			canceller_control_word_reg <= `WORD_RESET;
		end else begin
			canceller_control_word_reg <= control_word_next;
		end
	end

	// Boost mode and its armed flag move with the state, all on the same edge.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= canceller_pkg::BOOST_IDLE;
			boost_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			boost_reg <= boost_next;
			armed_reg <= armed_next;
		end
	end

	// The strobe marks the one cycle in which a new word first stands on the outputs.
	always_ff @(posedge clk) begin
		if (srst) begin
			band_undef_reg <= 1'b0;
			strobe_reg     <= 1'b0;
			active_reg     <= 1'b0;
		end else begin
			band_undef_reg <= band_undef_next;
			strobe_reg     <= frame_done;
			active_reg     <= ~act_sync_reg;
		end
	end

	// Every output below is a flip-flop or a slice of one; nothing combinational reaches a pin.
	// The band code passes through unchanged; the undefined code is flagged, not remapped.
	assign i_dac_value    = canceller_control_word_reg[`I_DAC_MSB:`I_DAC_LSB];
	assign q_dac_value    = canceller_control_word_reg[`Q_DAC_MSB:`Q_DAC_LSB];
	assign band_select    = canceller_control_word_reg[`BAND_MSB:`BAND_LSB];
	assign band_undefined = band_undef_reg;
	assign gain_switch    = canceller_control_word_reg[`GAIN_BIT];
	assign extended_bit   = canceller_control_word_reg[`EXT_BIT];
	assign boost_mode     = boost_reg;
	assign boost_armed    = armed_reg;
	assign word_strobe    = strobe_reg;
	assign chip_active    = active_reg;

endmodule

`default_nettype wire

/* File: rtl/serial_frame_shifter.sv */
// Shift register of the three-wire serial port, clocked by the host's serial clock.
// Assumes the host keeps the serial clock still while the select is high.
`timescale 1ns/1ps
`default_nettype none
`include "canceller_defs.svh"

module serial_frame_shifter (
	input  wire logic   sclk,
	input  wire logic   serial_select_low,
	input  wire logic   serial_data,
	serial_word_if.link bus
);

	logic [`WORD_W-1:0] shift_reg;

	// First bit in ends at frame position 23 after a full frame.
	always_ff @(posedge sclk) begin
		if (!serial_select_low) begin
			shift_reg <= {shift_reg[`WORD_W-2:0], serial_data};
		end
	end

	assign bus.frame_bits = shift_reg;

endmodule

`default_nettype wire

/* File: rtl/serial_word_if.sv */
// Carrier for the shifted frame between the link-clock shifter and the core.
// Assumes the frame is read by the core only while the link is idle.
`timescale 1ns/1ps
`default_nettype none
`include "canceller_defs.svh"

interface serial_word_if;
	logic [`WORD_W-1:0] frame_bits;

	modport link (output frame_bits);
	modport core (input frame_bits);
endinterface

`default_nettype wire
